/* File: hw/lin_phy_pkg.sv */
// How it works
// - Data bit 1 drives transmit input when the route selects data, otherwise the SCI transmit does
// - Data bit 0 shows receiver output, read-only
// - Enable cleared means shutdown, weak pullup only
// - Receive-only bit disables the transmitter
// - Wake-up enable gates standby wake detection
// - Pullup select, weak forced in shutdown and in standby without wake-up
// - Test registers writable only in special mode
// - Slope register writable only in shutdown
// - Timeout-disable bit turns off dominant supervision
// - Two-bit slope field selects edge rate
// - Standby dominant then rising edge sends wake pulse
// - Transmit input used only in normal mode
package lin_phy_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_PORT_DATA = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_TEST_A = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_SLOPE = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_TEST_B = 3'h4;
  localparam int BIT_TX_DRIVE = 1;
  localparam int BIT_RX_STATE = 0;
  localparam int BIT_ENABLE = 3;
  localparam int BIT_RX_ONLY = 2;
  localparam int BIT_WAKE_EN = 1;
  localparam int BIT_STRONG_PU = 0;
  localparam int BIT_TO_DIS = 7;
  localparam logic [DATA_W-1:0] RST_PORT_DATA = 8'h02;
  localparam logic [DATA_W-1:0] RST_CONTROL = 8'h00;
  localparam logic [DATA_W-1:0] RST_SLOPE = 8'h00;
  localparam logic [DATA_W-1:0] RST_TEST = 8'h00;
  localparam logic [1:0] SLOPE_NORMAL = 2'h0;
  localparam logic [1:0] SLOPE_SLOW = 2'h1;
  localparam logic [1:0] SLOPE_FAST = 2'h2;
  // Wake-up filter time in ns, and its count of cycles (least time, rounds up)
  localparam int WAKE_FILTER_NS = 1000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int WAKE_FILTER_CYC = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WCNT_W = 8;

  typedef enum logic [3:0] {
    MODE_SHUTDOWN = 4'h1,
    MODE_NORMAL = 4'h2,
    MODE_RECEIVE_ONLY_SEL = 4'h4,
    MODE_STANDBY = 4'h8
  } phy_mode_t;

  typedef struct packed {
    logic phy_enable;
    logic receive_only_sel;
    logic wakeup_enable;
    logic strong_pullup_sel;
    logic dominant_timeout_disable;
    logic [1:0] slope_select;
    logic transmitter_on;
    logic receiver_on;
  } phy_ctrl_t;
endpackage

/* File: hw/lin_phy_control_registers.sv */
`timescale 1ns/1ps
module lin_phy_control_registers
  import lin_phy_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic special_mode,
  input wire logic standby_req,
  input wire logic tx_route_is_data,
  input wire logic sci_transmit,
  input wire logic bus_level,
  input wire logic phy_receive_output,
  output logic phy_transmit_input,
  output logic tx_gated,
  output logic wakeup_pulse,
  output phy_ctrl_t phy_ctrl,
  output logic [DATA_W-1:0] test_a_out,
  output logic [DATA_W-1:0] test_b_out
);
  logic tx_drive_bit_reg;
  logic [3:0] control_reg;
  logic [2:0] slope_cfg_reg;
  logic [DATA_W-1:0] test_a_reg;
  logic [DATA_W-1:0] test_b_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic rx_meta_reg, rx_sync_reg, bus_meta_reg, bus_sync_reg, stby_meta_reg, stby_sync_reg;
  logic bus_prev_reg;
  logic [WCNT_W-1:0] dom_cnt_reg;
  logic [WCNT_W-1:0] dom_cnt_next;
  logic wake_reg;
  phy_mode_t mode;

  // Address decode
  wire hit_data = (reg_addr == OFS_PORT_DATA);
  wire hit_ctrl = (reg_addr == OFS_CONTROL);
  wire hit_ta = (reg_addr == OFS_TEST_A);
  wire hit_slope = (reg_addr == OFS_SLOPE);
  wire hit_tb = (reg_addr == OFS_TEST_B);
  wire enable = control_reg[BIT_ENABLE];
  wire wake_en = control_reg[BIT_WAKE_EN];
  wire slope_wr_ok = reg_wr && hit_slope && !enable;
  wire test_wr_ok = reg_wr && special_mode;

  // Inputs from the analog side and the mode pin are off-domain
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      bus_meta_reg <= 1'b1;
      bus_sync_reg <= 1'b1;
      stby_meta_reg <= 1'b0;
      stby_sync_reg <= 1'b0;
    end else begin
      rx_meta_reg <= phy_receive_output;
      rx_sync_reg <= rx_meta_reg;
      bus_meta_reg <= bus_level;
      bus_sync_reg <= bus_meta_reg;
      stby_meta_reg <= standby_req;
      stby_sync_reg <= stby_meta_reg;
    end
  end

  // Operating mode: shutdown wins, then standby, then receive-only
  always_comb begin
    if (!enable) begin
      mode = MODE_SHUTDOWN;
    end else if (stby_sync_reg) begin
      mode = MODE_STANDBY;
    end else if (control_reg[BIT_RX_ONLY]) begin
      mode = MODE_RECEIVE_ONLY_SEL;
    end else begin
      mode = MODE_NORMAL;
    end
  end

  // Control outputs to the analog transceiver
  assign phy_ctrl.phy_enable = enable;
  assign phy_ctrl.receive_only_sel = control_reg[BIT_RX_ONLY];
  assign phy_ctrl.wakeup_enable = wake_en && (mode == MODE_STANDBY);
  // Strong pullup is forced off in shutdown and in standby without wake-up
  assign phy_ctrl.strong_pullup_sel = control_reg[BIT_STRONG_PU] && (mode != MODE_SHUTDOWN) &&
                                      !((mode == MODE_STANDBY) && !wake_en);
  assign phy_ctrl.dominant_timeout_disable = slope_cfg_reg[2];
  assign phy_ctrl.slope_select = slope_cfg_reg[1:0];
  assign phy_ctrl.transmitter_on = (mode == MODE_NORMAL);
  assign phy_ctrl.receiver_on = (mode != MODE_SHUTDOWN);

  // Transmit source; recessive (high) unless the transmitter is in normal mode
  assign phy_transmit_input = tx_route_is_data ? tx_drive_bit_reg : sci_transmit;
  assign tx_gated = (mode == MODE_NORMAL) ? phy_transmit_input : 1'b1;
  assign test_a_out = test_a_reg;
  assign test_b_out = test_b_reg;

  // Register writes; slope register locked while enabled so slopes never change mid-frame
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_drive_bit_reg <= RST_PORT_DATA[BIT_TX_DRIVE];
      control_reg <= RST_CONTROL[3:0];
      slope_cfg_reg <= {RST_SLOPE[BIT_TO_DIS], RST_SLOPE[1:0]};
      test_a_reg <= RST_TEST;
      test_b_reg <= RST_TEST;
    end else begin
      if (reg_wr && hit_data) begin
        tx_drive_bit_reg <= reg_wdata[BIT_TX_DRIVE];
      end
      if (reg_wr && hit_ctrl) begin
        control_reg <= reg_wdata[3:0];
      end
      if (slope_wr_ok) begin
        slope_cfg_reg <= {reg_wdata[BIT_TO_DIS], reg_wdata[1:0]};
      end
      if (test_wr_ok && hit_ta) begin
        test_a_reg <= reg_wdata;
      end
      if (test_wr_ok && hit_tb) begin
        test_b_reg <= reg_wdata;
      end
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_next = '0;
    if (hit_data) begin
      rdata_next[BIT_TX_DRIVE] = tx_drive_bit_reg;
      rdata_next[BIT_RX_STATE] = rx_sync_reg;
    end else if (hit_ctrl) begin
      rdata_next[3:0] = control_reg;
    end else if (hit_ta) begin
      rdata_next = test_a_reg;
    end else if (hit_slope) begin
      rdata_next[BIT_TO_DIS] = slope_cfg_reg[2];
      rdata_next[1:0] = slope_cfg_reg[1:0];
    end else if (hit_tb) begin
      rdata_next = test_b_reg;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= reg_rd ? rdata_next : '0;
    end
  end
  assign reg_rdata = rdata_reg;

  // Dominant-length counter for standby wake-up; saturates to avoid wrap
  always_comb begin
    dom_cnt_next = dom_cnt_reg;
    if (!phy_ctrl.wakeup_enable || bus_sync_reg) begin
      dom_cnt_next = '0;
    end else if (dom_cnt_reg != WCNT_W'(WAKE_FILTER_CYC)) begin
      dom_cnt_next = dom_cnt_reg + WCNT_W'(1);
    end
  end

  // Wake pulse on the rising edge after a long enough dominant phase
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_prev_reg <= 1'b1;
      dom_cnt_reg <= '0;
      wake_reg <= 1'b0;
    end else begin
      bus_prev_reg <= bus_sync_reg;
      dom_cnt_reg <= dom_cnt_next;
      wake_reg <= phy_ctrl.wakeup_enable && bus_sync_reg && !bus_prev_reg &&
                  (dom_cnt_reg == WCNT_W'(WAKE_FILTER_CYC));
    end
  end
  assign wakeup_pulse = wake_reg;
endmodule

/* File: tb/lin_phy_regs_asserts.sv */
`timescale 1ns/1ps
module lin_phy_regs_asserts
  import lin_phy_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic special_mode,
  input wire logic tx_route_is_data,
  input wire logic sci_transmit,
  input wire logic phy_transmit_input,
  input wire logic tx_gated,
  input wire logic wakeup_pulse,
  input wire phy_ctrl_t phy_ctrl,
  input wire logic [DATA_W-1:0] test_a_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Slope write while running must bounce
  sequence slope_wr_on;
    reg_wr && reg_addr == OFS_SLOPE && phy_ctrl.phy_enable;
  endsequence
  a_slope_locked: assert property (slope_wr_on |=> $stable(phy_ctrl.slope_select))
    else $error("slope changed while on");
  a_test_locked: assert property (reg_wr && reg_addr == OFS_TEST_A && !special_mode |=> $stable(test_a_out))
    else $error("test reg written");
  a_route_sci: assert property (!tx_route_is_data |-> phy_transmit_input == sci_transmit)
    else $error("bad sci route");
  a_route_data: assert property (reg_wr && reg_addr == OFS_PORT_DATA ##1 tx_route_is_data
    |-> phy_transmit_input == $past(reg_wdata[BIT_TX_DRIVE]))
    else $error("bad data route");
  a_off_weak: assert property (!phy_ctrl.phy_enable |-> !phy_ctrl.strong_pullup_sel && !phy_ctrl.transmitter_on)
    else $error("shutdown not off");
  a_receive_only_sel_notx: assert property (phy_ctrl.receive_only_sel |-> !phy_ctrl.transmitter_on)
    else $error("tx on in rx-only");
  a_gated_tx: assert property (tx_gated == (phy_ctrl.transmitter_on ? phy_transmit_input : 1'h1))
    else $error("tx used outside normal");
  a_ctrl_zero: assert property (reg_rd && reg_addr == OFS_CONTROL |=> reg_rdata[7:4] == 4'h0)
    else $error("unused bits set");
  a_wake_single: assert property (wakeup_pulse |=> !wakeup_pulse)
    else $error("wake pulse too long");
endmodule

/* File: tb/lin_bus_model.sv */
`timescale 1ns/1ps
// Bus with pullup: recessive unless our transmitter or a remote node pulls low
module lin_bus_model (
  input wire logic tx_gated,
  input wire logic remote_dom,
  output logic bus_level,
  output logic rx_out
);
  // Wired-and; the receiver simply follows the wire
  assign bus_level = tx_gated & ~remote_dom;
  assign rx_out = bus_level;
endmodule

/* File: tb/lin_phy_control_registers_bench.sv */
`timescale 1ns/1ps
module lin_phy_control_registers_bench;
  import lin_phy_pkg::*;
  logic clk = 1'h0, arst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, remote_dom = 1'h0;
  logic special_mode = 1'h0, standby_req = 1'h0, tx_route_is_data = 1'h1, sci_transmit = 1'h1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, test_a_out, test_b_out, got, r;
  logic bus_level, rx_out, phy_transmit_input, tx_gated, wakeup_pulse;
  phy_ctrl_t phy_ctrl;
  int errors = 0, comparisons = 0, seed = 32'hdc2f, i, m_data = 2, m_ctrl = 0, m_slope = 0, m_ta = 0, m_tb = 0;
  lin_phy_control_registers dut_u (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .special_mode(special_mode), .standby_req(standby_req),
    .tx_route_is_data(tx_route_is_data), .sci_transmit(sci_transmit), .bus_level(bus_level),
    .phy_receive_output(rx_out), .phy_transmit_input(phy_transmit_input), .tx_gated(tx_gated),
    .wakeup_pulse(wakeup_pulse), .phy_ctrl(phy_ctrl), .test_a_out(test_a_out), .test_b_out(test_b_out));
  lin_bus_model bus_u (.tx_gated(tx_gated), .remote_dom(remote_dom), .bus_level(bus_level), .rx_out(rx_out));
  initial forever #50 clk = ~clk;
  // Reference: receiver level follows the transmitter only in normal mode
  function automatic logic rx_exp();
    if ((m_ctrl & 12) != 8 || standby_req) return 1'h1;
    return tx_route_is_data ? m_data[1] : sci_transmit;
  endfunction
  function automatic logic [7:0] rd_exp(input int ad);
    case (ad)
      0: return 8'(m_data | rx_exp());
      1: return 8'(m_ctrl);
      2: return 8'(m_ta);
      3: return 8'(m_slope);
      4: return 8'(m_tb);
      default: return 8'h00;
    endcase
  endfunction
  task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task test_done;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Write, then update the reference as the device would
  task wr(input logic [2:0] ad, input logic [7:0] dt);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= ad;
    reg_wdata <= dt;
    @(posedge clk);
    reg_wr <= 1'h0;
    case (ad)
      0: m_data = dt & 2;
      1: m_ctrl = dt & 15;
      2: if (special_mode) m_ta = dt;
      3: if (!m_ctrl[3]) m_slope = dt & 8'h83;
      4: if (special_mode) m_tb = dt;
      default: ;
    endcase
  endtask
  task rd(input logic [2:0] ad);
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 check(reg_rdata, rd_exp(ad), "read data");
  endtask
  // Remote dominant of len cycles; expect a wake pulse within 8 cycles or none
  task wake(input int len, input logic exp);
    logic hit;
    hit = 1'h0;
    remote_dom <= 1'h1;
    repeat (len) @(posedge clk);
    remote_dom <= 1'h0;
    repeat (8) @(negedge clk) hit = hit | (wakeup_pulse === 1'h1);
    check(hit, exp, "wake pulse");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'h1;
    for (i = 0; i < 8; i++) rd(3'(i));
    for (i = 0; i < 80; i++) begin
      r = 8'($random(seed));
      special_mode <= r[0];
      standby_req <= r[1] & r[2];
      tx_route_is_data <= r[3];
      sci_transmit <= r[4];
      wr(r[7:5], 8'($random(seed)));
      repeat (4) @(posedge clk);
      #1 check(tx_gated, rx_exp(), "gated tx");
      check(phy_ctrl.strong_pullup_sel, m_ctrl[0] & m_ctrl[3] & ~(standby_req & ~m_ctrl[1]), "pullup");
      check(phy_ctrl.slope_select, m_slope & 3, "slope");
      check(phy_ctrl.dominant_timeout_disable, m_slope[7], "timeout off");
      check(phy_transmit_input, tx_route_is_data ? m_data[1] : sci_transmit, "tx source");
      check(phy_ctrl.phy_enable, m_ctrl[3], "enable");
      check(phy_ctrl.receiver_on, m_ctrl[3], "receiver on");
      check(phy_ctrl.receive_only_sel, m_ctrl[2], "rx only sel");
      check(phy_ctrl.transmitter_on, m_ctrl[3] & ~m_ctrl[2] & ~standby_req, "transmitter on");
      check(phy_ctrl.wakeup_enable, m_ctrl[3] & m_ctrl[1] & standby_req, "wake enable");
      check(test_a_out, m_ta, "test a");
      check(test_b_out, m_tb, "test b");
      rd(3'($random(seed)));
    end
    // Standby: long dominant wakes, short does not, disabled never wakes
    standby_req <= 1'h1;
    wr(1, 8'h0a);
    repeat (4) @(posedge clk);
    wake(12, 1'h1);
    wake(5, 1'h0);
    wr(1, 8'h08);
    wake(12, 1'h0);
    test_done();
  end
endmodule
bind lin_phy_control_registers lin_phy_regs_asserts chk_u (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .special_mode(special_mode),
  .tx_route_is_data(tx_route_is_data), .sci_transmit(sci_transmit), .phy_transmit_input(phy_transmit_input),
  .tx_gated(tx_gated), .wakeup_pulse(wakeup_pulse), .phy_ctrl(phy_ctrl), .test_a_out(test_a_out));
